//--- verilog/qec_pkg.sv
// quadrature encoder control: shared offsets, fields, reset values
// assumes a 16-bit register port with word indices
package qec_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 3;
  // register indices
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_IOCF = 3'h1;
  localparam logic [2:0] REG_POSL = 3'h2;
  localparam logic [2:0] REG_POSH = 3'h3;
  localparam logic [2:0] REG_INIL = 3'h4;
  localparam logic [2:0] REG_INIH = 3'h5;
  localparam logic [2:0] REG_GECL = 3'h6;
  localparam logic [2:0] REG_GECH = 3'h7;
  // control field positions
  localparam int unsigned B_RUN = 15;
  localparam int unsigned B_IDL = 13;
  localparam int unsigned B_PIM = 10;
  localparam int unsigned B_IMB = 9;
  localparam int unsigned B_IMA = 8;
  localparam int unsigned B_DIV = 4;
  localparam int unsigned B_CCM = 0;
  localparam logic [15:0] CTRL_MASK  = 16'hBF73;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // io config: bit0 swap, bit1 a invert, bit2 b invert, bit3 sticky index flag (read, write 1 to clear)
  localparam int unsigned B_SWP = 0;
  localparam int unsigned B_APL = 1;
  localparam int unsigned B_BPL = 2;
  localparam logic [15:0] IOCF_MASK  = 16'h0007;
  localparam logic [15:0] IOCF_RESET = 16'h0000;
  typedef enum logic [2:0] {
    PIM_NONE  = 3'b000,
    PIM_RST   = 3'b001,
    PIM_NEXT  = 3'b010,
    PIM_HOME1 = 3'b011,
    PIM_HOME2 = 3'b100,
    PIM_GEC   = 3'b101,
    PIM_MOD   = 3'b110,
    PIM_RSVD  = 3'b111
  } qec_pim_t;
  typedef enum logic [1:0] {
    CCM_QUAD = 2'b00,
    CCM_DIR  = 2'b01,
    CCM_TMR0 = 2'b10,
    CCM_TMR1 = 2'b11
  } qec_ccm_t;
  typedef struct packed {
    logic a;
    logic b;
    logic idx;
    logic home;
  } qec_pins_t;
endpackage : qec_pkg

//--- verilog/qec_filter.sv
// quadrature encoder control: one-pin digital noise filter
// assumes the pin is synchronous to clk and tick is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module qec_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] hist_r;
  logic [2:0] hist_nxt;
  logic       out_r;
  logic       out_nxt;

  // three agreeing ticks needed before the output moves
  always_comb begin
    hist_nxt = tick ? {hist_r[1:0], din} : hist_r;
    out_nxt  = out_r;
    if (tick && hist_nxt == 3'h7) begin
      out_nxt = 1'b1;
    end else if (tick && hist_nxt == 3'h0) begin
      out_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_r <= 3'h0;
      out_r  <= 1'b0;
    end else begin
      hist_r <= hist_nxt;
      out_r  <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule : qec_filter
`default_nettype wire

//--- verilog/qec_core.sv
// quadrature encoder control: register file, decoder and position counter
// assumes pins synchronous to clk, single-cycle register strobes, read data next cycle
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module qec_core #(
  parameter int unsigned CW = 32
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     idle_mode,
  input  wire logic                     phase_a_input,
  input  wire logic                     phase_b_input,
  input  wire logic                     index_input,
  input  wire logic                     home_input,
  input  wire logic [qec_pkg::AW-1:0]   addr,
  input  wire logic [qec_pkg::DW-1:0]   wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [qec_pkg::DW-1:0]   rdata,
  output logic                          count_dir,
  output logic                          index_seen
);
  logic [15:0]   ctrl_r, ctrl_nxt;
  logic [15:0]   iocf_r, iocf_nxt;
  logic [CW-1:0] pos_r, pos_nxt;
  logic [CW-1:0] ini_r, ini_nxt;
  logic [CW-1:0] gec_r, gec_nxt;
  logic [15:0]   rdata_r, rdata_nxt;
  logic [7:0]    div_r, div_nxt;
  logic          tick;
  logic [1:0]    homes_r, homes_nxt;
  logic          armed_r, armed_nxt;
  logic          dir_r, dir_nxt;
  logic          idxs_r, idxs_nxt;
  logic          fa_r, fb_r, fi_r, fh_r;
  qec_pkg::qec_pins_t pins, fpins;

  // control and io config fields
  logic          counter_run_enable;
  logic          idle_stop_select;
  qec_pkg::qec_pim_t position_init_mode;
  logic          phase_b_match_level;
  logic          phase_a_match_level;
  logic [2:0]    filter_clock_divider;
  qec_pkg::qec_ccm_t counter_mode_select;
  logic          phase_swap_select;
  logic          phase_a_invert;
  logic          phase_b_invert;

  assign counter_run_enable   = ctrl_r[qec_pkg::B_RUN];
  assign idle_stop_select     = ctrl_r[qec_pkg::B_IDL];
  assign position_init_mode   = qec_pkg::qec_pim_t'(ctrl_r[qec_pkg::B_PIM +: 3]);
  assign phase_b_match_level  = ctrl_r[qec_pkg::B_IMB];
  assign phase_a_match_level  = ctrl_r[qec_pkg::B_IMA];
  assign filter_clock_divider = ctrl_r[qec_pkg::B_DIV +: 3];
  assign counter_mode_select  = qec_pkg::qec_ccm_t'(ctrl_r[qec_pkg::B_CCM +: 2]);
  assign phase_swap_select    = iocf_r[qec_pkg::B_SWP];
  assign phase_a_invert       = iocf_r[qec_pkg::B_APL];
  assign phase_b_invert       = iocf_r[qec_pkg::B_BPL];

  // swap and polarity applied before filtering and matching
  always_comb begin
    pins.a    = (phase_swap_select ? phase_b_input : phase_a_input) ^ phase_a_invert;
    pins.b    = (phase_swap_select ? phase_a_input : phase_b_input) ^ phase_b_invert;
    pins.idx  = index_input;
    pins.home = home_input;
  end

  // filter clock = clk / 2^divider; software keeps it fast enough
  always_comb begin
    div_nxt = div_r + 8'h01;
    tick    = 1'b0;
    if (div_r >= ((8'h01 << filter_clock_divider) - 8'h01)) begin
      div_nxt = 8'h00;
      tick    = 1'b1;
    end
  end

  qec_filter u_fa (.clk(clk), .rst_n(rst_n), .tick(tick), .din(pins.a),    .dout(fpins.a));
  qec_filter u_fb (.clk(clk), .rst_n(rst_n), .tick(tick), .din(pins.b),    .dout(fpins.b));
  qec_filter u_fi (.clk(clk), .rst_n(rst_n), .tick(tick), .din(pins.idx),  .dout(fpins.idx));
  qec_filter u_fh (.clk(clk), .rst_n(rst_n), .tick(tick), .din(pins.home), .dout(fpins.home));

  logic active, timer_mode, idx_evt, home_evt, match, step_up, step_dn, at_gec;
  logic [CW-1:0] pos_step;

  always_comb begin
    active     = counter_run_enable && !(idle_stop_select && idle_mode);
    timer_mode = counter_mode_select == qec_pkg::CCM_TMR0 ||
                 counter_mode_select == qec_pkg::CCM_TMR1;
    idx_evt    = fpins.idx && !fi_r;
    home_evt   = fpins.home && !fh_r;
    match      = (fpins.a == phase_a_match_level) &&
                 (fpins.b == phase_b_match_level);
    step_up    = 1'b0;
    step_dn    = 1'b0;
    if (timer_mode) begin
      step_up = 1'b1;
    end else if (counter_mode_select == qec_pkg::CCM_QUAD) begin
      // gray-code state change: direction from which phase leads
      if (fpins.a != fa_r && fpins.b == fb_r) begin
        step_up = fpins.a ^ fpins.b ^ 1'b1;
        step_dn = fpins.a ^ fpins.b;
      end else if (fpins.b != fb_r && fpins.a == fa_r) begin
        step_up = fpins.a ^ fpins.b;
        step_dn = fpins.a ^ fpins.b ^ 1'b1;
      end
    end else if (fpins.a && !fa_r) begin
      step_up = fpins.b;
      step_dn = !fpins.b;
    end
    at_gec   = pos_r == gec_r;
    pos_step = pos_r;
    if (step_up) begin
      if (position_init_mode == qec_pkg::PIM_MOD && !timer_mode && at_gec) begin
        pos_step = ini_r;
      end else begin
        pos_step = pos_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end else if (step_dn) begin
      if (position_init_mode == qec_pkg::PIM_MOD && !timer_mode && pos_r == ini_r) begin
        pos_step = gec_r;
      end else begin
        pos_step = pos_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // counter, init modes, home tracking
  always_comb begin
    pos_nxt   = pos_r;
    homes_nxt = homes_r;
    armed_nxt = armed_r;
    dir_nxt   = dir_r;
    idxs_nxt  = idxs_r | idx_evt;
    if (active) begin
      pos_nxt = pos_step;
      if (step_up || step_dn) begin
        dir_nxt = step_up;
      end
      if (home_evt) begin
        homes_nxt = 2'h0;
        armed_nxt = 1'b1;
      end
      if (!timer_mode && idx_evt) begin
        case (position_init_mode)
          qec_pkg::PIM_NONE: begin
            pos_nxt = pos_step;
          end
          qec_pkg::PIM_RST: begin
            pos_nxt = '0;
          end
          qec_pkg::PIM_NEXT: begin
            if (armed_r) begin
              pos_nxt   = ini_r;
              armed_nxt = 1'b0;
            end
          end
          qec_pkg::PIM_HOME1, qec_pkg::PIM_HOME2: begin
            if (armed_r && !home_evt) begin
              homes_nxt = homes_r + 2'h1;
              if ((position_init_mode == qec_pkg::PIM_HOME1 && homes_r == 2'h0) ||
                  (position_init_mode == qec_pkg::PIM_HOME2 && homes_r == 2'h1)) begin
                pos_nxt   = ini_r;
                armed_nxt = 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
        if (counter_mode_select == qec_pkg::CCM_QUAD && match &&
            position_init_mode != qec_pkg::PIM_NEXT &&
            position_init_mode != qec_pkg::PIM_HOME1 &&
            position_init_mode != qec_pkg::PIM_HOME2) begin
          pos_nxt = '0;
        end
      end
      if (!timer_mode && position_init_mode == qec_pkg::PIM_GEC && at_gec) begin
        pos_nxt = '0;
      end
    end
    if (wr && addr == qec_pkg::REG_CTRL &&
        wdata[qec_pkg::B_PIM +: 3] == qec_pkg::PIM_NEXT) begin
      armed_nxt = 1'b1;
    end
  end

  // register writes; hardware counter update yields to a software write
  always_comb begin
    ctrl_nxt  = ctrl_r;
    iocf_nxt  = iocf_r;
    ini_nxt   = ini_r;
    gec_nxt   = gec_r;
    rdata_nxt = 16'h0000;
    if (wr) begin
      if (addr == qec_pkg::REG_CTRL) begin
        ctrl_nxt = wdata & qec_pkg::CTRL_MASK;
      end else if (addr == qec_pkg::REG_IOCF) begin
        iocf_nxt = wdata & qec_pkg::IOCF_MASK;
      end else if (addr == qec_pkg::REG_INIL) begin
        ini_nxt[15:0] = wdata;
      end else if (addr == qec_pkg::REG_INIH) begin
        ini_nxt[CW-1:16] = wdata[CW-17:0];
      end else if (addr == qec_pkg::REG_GECL) begin
        gec_nxt[15:0] = wdata;
      end else if (addr == qec_pkg::REG_GECH) begin
        gec_nxt[CW-1:16] = wdata[CW-17:0];
      end
    end
    if (rd) begin
      if (addr == qec_pkg::REG_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (addr == qec_pkg::REG_IOCF) begin
        rdata_nxt = {12'h000, idxs_r, iocf_r[2:0]};
      end else if (addr == qec_pkg::REG_POSL) begin
        rdata_nxt = pos_r[15:0];
      end else if (addr == qec_pkg::REG_POSH) begin
        rdata_nxt = pos_r[CW-1:16];
      end else if (addr == qec_pkg::REG_INIL) begin
        rdata_nxt = ini_r[15:0];
      end else if (addr == qec_pkg::REG_INIH) begin
        rdata_nxt = ini_r[CW-1:16];
      end else if (addr == qec_pkg::REG_GECL) begin
        rdata_nxt = gec_r[15:0];
      end else begin
        rdata_nxt = gec_r[CW-1:16];
      end
    end
  end

  logic [CW-1:0] pos_fin;
  logic          idxs_fin;
  always_comb begin
    pos_fin  = pos_nxt;
    // writes stay possible while stopped
    if (wr && addr == qec_pkg::REG_POSL) begin
      pos_fin[15:0] = wdata;
    end else if (wr && addr == qec_pkg::REG_POSH) begin
      pos_fin[CW-1:16] = wdata[CW-17:0];
    end
    // sticky index flag: write 1 to clear, a new index wins
    idxs_fin = idxs_nxt;
    if (wr && addr == qec_pkg::REG_IOCF && wdata[3] && !idx_evt) begin
      idxs_fin = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r  <= qec_pkg::CTRL_RESET;
      iocf_r  <= qec_pkg::IOCF_RESET;
      pos_r   <= '0;
      ini_r   <= '0;
      gec_r   <= '0;
      rdata_r <= 16'h0000;
      div_r   <= 8'h00;
      homes_r <= 2'h0;
      armed_r <= 1'b0;
      dir_r   <= 1'b0;
      idxs_r  <= 1'b0;
      fa_r    <= 1'b0;
      fb_r    <= 1'b0;
      fi_r    <= 1'b0;
      fh_r    <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      iocf_r  <= iocf_nxt;
      pos_r   <= pos_fin;
      ini_r   <= ini_nxt;
      gec_r   <= gec_nxt;
      rdata_r <= rdata_nxt;
      div_r   <= div_nxt;
      homes_r <= homes_nxt;
      armed_r <= armed_nxt;
      dir_r   <= dir_nxt;
      idxs_r  <= idxs_fin;
      fa_r    <= fpins.a;
      fb_r    <= fpins.b;
      fi_r    <= fpins.idx;
      fh_r    <= fpins.home;
    end
  end

  assign rdata      = rdata_r;
  assign count_dir  = dir_r;
  assign index_seen = idxs_r;

  // checks
  property p_stopped_holds;
    @(posedge clk) disable iff (!rst_n)
    (!counter_run_enable && !wr) |=> $stable(pos_r);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("counter moved while disabled");

  property p_idle_holds;
    @(posedge clk) disable iff (!rst_n)
    (idle_mode && idle_stop_select && !wr) |=> $stable(pos_r);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("counter moved in idle stop");

  property p_index_reset;
    @(posedge clk) disable iff (!rst_n)
    (active && !timer_mode && idx_evt && position_init_mode == qec_pkg::PIM_RST && !wr) |=> pos_r == '0;
  endproperty
  a_index_reset: assert property (p_index_reset) else $error("index did not clear counter");

  property p_next_load;
    @(posedge clk) disable iff (!rst_n)
    (active && !timer_mode && idx_evt && armed_r && position_init_mode == qec_pkg::PIM_NEXT && !wr)
      |=> pos_r == $past(ini_r);
  endproperty
  a_next_load: assert property (p_next_load) else $error("next index did not load init value");

  property p_gec_reset;
    @(posedge clk) disable iff (!rst_n)
    (active && !timer_mode && at_gec && position_init_mode == qec_pkg::PIM_GEC && !wr) |=> pos_r == '0;
  endproperty
  a_gec_reset: assert property (p_gec_reset) else $error("compare equality did not clear counter");

  property p_timer_counts;
    @(posedge clk) disable iff (!rst_n)
    (active && timer_mode && !wr) |=> pos_r == $past(pos_r) + {{(CW-1){1'b0}}, 1'b1};
  endproperty
  a_timer_counts: assert property (p_timer_counts) else $error("timer mode did not count");

  property p_match_reset;
    @(posedge clk) disable iff (!rst_n)
    (active && counter_mode_select == qec_pkg::CCM_QUAD && idx_evt && match &&
     position_init_mode == qec_pkg::PIM_NONE && !wr) |=> pos_r == '0;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("index match did not clear counter");

  sequence s_up_step;
    active && counter_mode_select == qec_pkg::CCM_QUAD && step_up && !idx_evt &&
    position_init_mode == qec_pkg::PIM_NONE && !wr;
  endsequence
  property p_quad_up;
    @(posedge clk) disable iff (!rst_n)
    s_up_step |=> pos_r == $past(pos_r) + {{(CW-1){1'b0}}, 1'b1};
  endproperty
  a_quad_up: assert property (p_quad_up) else $error("forward step not counted");
endmodule : qec_core
`default_nettype wire

//--- tb/qec_enc_model.sv
// quadrature encoder control: behavioural incremental encoder for the bench
// assumes its tasks are called one at a time, right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module qec_enc_model #(
  parameter int unsigned HOLD = 12
) (
  input  wire logic               clk,
  output var  qec_pkg::qec_pins_t pins
);
  initial pins = '0;
  // every level stands well past the three-tick filter
  task automatic settle();
    repeat (HOLD) @(posedge clk);
  endtask : settle
  // up means phase b leads phase a, the core's forward direction
  task automatic step(input logic up);
    logic [1:0] nxt;
    case ({pins.a, pins.b})
      2'b00:   nxt = up ? 2'b01 : 2'b10;
      2'b01:   nxt = up ? 2'b11 : 2'b00;
      2'b11:   nxt = up ? 2'b10 : 2'b01;
      default: nxt = up ? 2'b00 : 2'b11;
    endcase
    @(posedge clk);
    pins.a <= nxt[1];
    pins.b <= nxt[0];
    settle();
  endtask : step
  task automatic pulse(input logic home);
    @(posedge clk);
    if (home) pins.home <= 1'b1;
    else pins.idx <= 1'b1;
    settle();
    pins.home <= 1'b0;
    pins.idx  <= 1'b0;
    settle();
  endtask : pulse
endmodule : qec_enc_model
`default_nettype wire

//--- tb/qec_core_tb.sv
// quadrature encoder control: self-checking bench for the core
// assumes the encoder model above and the core's register map
`timescale 1ns/1ps
`default_nettype none
module qec_core_tb;
  localparam int unsigned HOLD = 12;
  logic                   clk;
  logic                   rst_n;
  logic                   idle_mode;
  logic [qec_pkg::AW-1:0] addr;
  logic [qec_pkg::DW-1:0] wdata;
  logic                   wr;
  logic                   rd;
  logic [qec_pkg::DW-1:0] rdata;
  logic                   count_dir;
  logic                   index_seen;
  qec_pkg::qec_pins_t     pins;
  int                     fail_count = 0;
  int                     compares   = 0;
  logic [15:0]            d;
  logic [15:0]            e;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  qec_enc_model #(.HOLD(HOLD)) qec_enc_model_inst (.clk(clk), .pins(pins));

  qec_core #(.CW(32)) qec_core_inst (
    .clk(clk), .rst_n(rst_n), .idle_mode(idle_mode),
    .phase_a_input(pins.a), .phase_b_input(pins.b),
    .index_input(pins.idx), .home_input(pins.home),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .count_dir(count_dir), .index_seen(index_seen)
  );

  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic reg_wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd

  task automatic pair_wr(input logic [2:0] a, input logic [31:0] v);
    reg_wr(a, v[15:0]);
    reg_wr(a + 3'h1, v[31:16]);
  endtask : pair_wr

  task automatic pos_is(input logic [31:0] exp);
    logic [15:0] lo;
    logic [15:0] hi;
    reg_rd(qec_pkg::REG_POSL, lo);
    reg_rd(qec_pkg::REG_POSH, hi);
    chk({hi, lo}, exp);
  endtask : pos_is

  function automatic logic [15:0] cw(input logic [2:0] pim, input logic [1:0] imv, input logic [1:0] ccm);
    return (16'h0001 << qec_pkg::B_RUN) | (16'(pim) << qec_pkg::B_PIM) | (16'(imv) << qec_pkg::B_IMA) | 16'(ccm);
  endfunction : cw

  task automatic t_regs();
    reg_rd(qec_pkg::REG_CTRL, d);
    chk(d, 16'h0000);
    reg_rd(qec_pkg::REG_IOCF, d);
    chk(d, 16'h0000);
    reg_wr(qec_pkg::REG_CTRL, 16'h7FFF);
    reg_rd(qec_pkg::REG_CTRL, d);
    chk(d, 16'h3F73);
    reg_wr(qec_pkg::REG_CTRL, 16'h0000);
    pair_wr(qec_pkg::REG_POSL, 32'h0001_1234);
    pos_is(32'h0001_1234);
  endtask : t_regs

  task automatic t_quad();
    pair_wr(qec_pkg::REG_POSL, 32'h0);
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_NONE, 2'b00, qec_pkg::CCM_QUAD));
    repeat (4) qec_enc_model_inst.step(1'b1);
    pos_is(32'h4);
    chk_bit(count_dir, 1'b1);
    repeat (2) qec_enc_model_inst.step(1'b0);
    pos_is(32'h2);
    chk_bit(count_dir, 1'b0);
    reg_wr(qec_pkg::REG_CTRL, 16'h0000);
    qec_enc_model_inst.step(1'b1);
    qec_enc_model_inst.step(1'b0);
    pos_is(32'h2);
  endtask : t_quad

  // counts made while stopped come back to the same phase levels
  task automatic t_idle();
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_NONE, 2'b00, qec_pkg::CCM_QUAD) | 16'h2000);
    @(posedge clk) idle_mode <= 1'b1;
    qec_enc_model_inst.step(1'b1);
    qec_enc_model_inst.step(1'b0);
    pos_is(32'h2);
    @(posedge clk) idle_mode <= 1'b0;
    qec_enc_model_inst.step(1'b1);
    pos_is(32'h3);
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_NONE, 2'b00, qec_pkg::CCM_QUAD));
    @(posedge clk) idle_mode <= 1'b1;
    qec_enc_model_inst.step(1'b1);
    pos_is(32'h4);
    @(posedge clk) idle_mode <= 1'b0;
  endtask : t_idle

  // phases sit at a=1 b=0 from here until t_compare steps them
  task automatic t_match();
    qec_enc_model_inst.step(1'b0);
    for (int i = 0; i < 4; i++) begin
      pair_wr(qec_pkg::REG_POSL, 32'h10);
      reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_NONE, 2'(i), qec_pkg::CCM_QUAD));
      qec_enc_model_inst.pulse(1'b0);
      pos_is((i == 1) ? 32'h0 : 32'h10);
    end
    chk_bit(index_seen, 1'b1);
    reg_wr(qec_pkg::REG_IOCF, 16'h0008);
    // flag drops at the edge that takes the write
    #1 chk_bit(index_seen, 1'b0);
    pair_wr(qec_pkg::REG_POSL, 32'h10);
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_RST, 2'b10, qec_pkg::CCM_QUAD));
    qec_enc_model_inst.pulse(1'b0);
    pos_is(32'h0);
  endtask : t_match

  task automatic t_polarity();
    logic [2:0] cfg [3] = '{3'h1, 3'h2, 3'h4};
    logic [1:0] imv [3] = '{2'b10, 2'b00, 2'b11};
    for (int i = 0; i < 3; i++) begin
      reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_NONE, imv[i], qec_pkg::CCM_QUAD));
      reg_wr(qec_pkg::REG_IOCF, 16'(cfg[i]));
      repeat (HOLD) @(posedge clk);
      pair_wr(qec_pkg::REG_POSL, 32'h10);
      qec_enc_model_inst.pulse(1'b0);
      pos_is(32'h0);
      reg_wr(qec_pkg::REG_IOCF, 16'h0000);
      repeat (HOLD) @(posedge clk);
    end
  endtask : t_polarity

  task automatic t_load();
    logic [2:0] pim [3] = '{qec_pkg::PIM_NEXT, qec_pkg::PIM_HOME1, qec_pkg::PIM_HOME2};
    pair_wr(qec_pkg::REG_INIL, 32'h1234_5678);
    for (int i = 0; i < 3; i++) begin
      reg_wr(qec_pkg::REG_CTRL, cw(pim[i], 2'b00, qec_pkg::CCM_QUAD));
      pair_wr(qec_pkg::REG_POSL, 32'h40);
      if (i > 0) begin
        qec_enc_model_inst.pulse(1'b0);
        pos_is(32'h40);
        qec_enc_model_inst.pulse(1'b1);
      end
      if (i == 2) begin
        qec_enc_model_inst.pulse(1'b0);
        pos_is(32'h40);
      end
      qec_enc_model_inst.pulse(1'b0);
      pos_is(32'h1234_5678);
      pair_wr(qec_pkg::REG_POSL, 32'h41);
      qec_enc_model_inst.pulse(1'b0);
      pos_is(32'h41);
    end
  endtask : t_load

  task automatic t_compare();
    pair_wr(qec_pkg::REG_GECL, 32'h3);
    pair_wr(qec_pkg::REG_POSL, 32'h0);
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_GEC, 2'b00, qec_pkg::CCM_QUAD));
    repeat (2) qec_enc_model_inst.step(1'b1);
    pos_is(32'h2);
    qec_enc_model_inst.step(1'b1);
    pos_is(32'h0);
    // leave compare mode first, else the preset below clears at once
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_MOD, 2'b00, qec_pkg::CCM_QUAD));
    pair_wr(qec_pkg::REG_INIL, 32'h0);
    pair_wr(qec_pkg::REG_GECL, 32'h2);
    pair_wr(qec_pkg::REG_POSL, 32'h2);
    qec_enc_model_inst.step(1'b1);
    pos_is(32'h0);
    qec_enc_model_inst.step(1'b0);
    pos_is(32'h2);
  endtask : t_compare

  // two reads two cycles apart, then an index that must not clear;
  // pulse plus read is 2*HOLD+3 edges after the second read
  task automatic t_timer();
    for (int i = 2; i < 4; i++) begin
      reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_RST, 2'b00, 2'(i)));
      reg_rd(qec_pkg::REG_POSL, d);
      reg_rd(qec_pkg::REG_POSL, e);
      chk(32'(e - d), 32'h2);
      qec_enc_model_inst.pulse(1'b0);
      reg_rd(qec_pkg::REG_POSL, d);
      chk(32'(d - e), 32'(2 * HOLD + 3));
    end
    reg_wr(qec_pkg::REG_CTRL, 16'h0000);
  endtask : t_timer

  // direction mode with a slower filter clock; phases start at a=1 b=1
  task automatic t_dir();
    pair_wr(qec_pkg::REG_POSL, 32'h10);
    reg_wr(qec_pkg::REG_CTRL, cw(qec_pkg::PIM_NONE, 2'b00, qec_pkg::CCM_DIR) | 16'h0010);
    repeat (4) qec_enc_model_inst.step(1'b1);
    pos_is(32'h11);
    chk_bit(count_dir, 1'b1);
    repeat (4) qec_enc_model_inst.step(1'b0);
    pos_is(32'h10);
    chk_bit(count_dir, 1'b0);
    reg_wr(qec_pkg::REG_CTRL, 16'h0000);
  endtask : t_dir

  initial begin
    rst_n     <= 1'b0;
    idle_mode <= 1'b0;
    addr      <= '0;
    wdata     <= '0;
    wr        <= 1'b0;
    rd        <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_quad();
    t_idle();
    t_match();
    t_polarity();
    t_load();
    t_compare();
    t_timer();
    t_dir();
    conclude();
  end

  // whole run needs about 1250 cycles; some thirty times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : qec_core_tb
`default_nettype wire
